// ===== tco_engine.sv
`timescale 1ns/1ps
// Function
// - sum only with request, first-segment, global enable
// - summing runs from start offset to end
// - checksum overwrites two bytes at insert offset
// - no request bit: frame passes unchanged
// - preamble word is never sent onward
// - end-around carry sum, complement inserted
// - zero result inserted as zero
// - checksum written into outgoing stream
// - odd byte padded with zero high byte
// - earlier byte low, later byte high
module tco_engine #(
   parameter int DEPTH = 2048
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_last,
   output logic in_ready,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   // depth must address cleanly with the offset counter
   if (DEPTH < 16 || DEPTH > 4096 || (1 << AW) != DEPTH) begin : g_depth_chk
      $error("DEPTH must be a power of two in 16..4096");
   end

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   logic glob_en_ff;
   logic nxt_glob_en;
   logic hit_ctrl;
   logic hit_stat;
   tco_pkg::tco_state_t state_ff;
   tco_pkg::tco_state_t nxt_state;
   logic engage_ff;
   logic nxt_engage;
   logic [15:0] csum_ff;
   logic [15:0] nxt_csum;

   // decode and register write
   always_comb begin
      hit_ctrl = (paddr == tco_pkg::ADDR_CTRL);
      hit_stat = (paddr == tco_pkg::ADDR_STATUS);
      pready = 1'b1;
      pslverr = psel && penable && !(hit_ctrl || hit_stat);
      nxt_glob_en = glob_en_ff;
      if (psel && penable && pwrite && hit_ctrl)
         nxt_glob_en = pwdata[tco_pkg::CTRL_ENABLE_BIT];
      prdata = 32'h0000_0000;
      if (hit_ctrl)
         prdata[tco_pkg::CTRL_ENABLE_BIT] = glob_en_ff;
      if (hit_stat) begin
         prdata[15:0] = csum_ff;
         prdata[tco_pkg::STAT_ENGAGED_BIT] = engage_ff;
         prdata[tco_pkg::STAT_BUSY_BIT] = (state_ff != tco_pkg::ST_CMDA);
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         glob_en_ff <= tco_pkg::CTRL_ENABLE_RST;
      else
         glob_en_ff <= nxt_glob_en;
   end

   // ------------------------------------------------------------
   // frame engine
   // ------------------------------------------------------------
   logic [7:0] mem [DEPTH];
   logic [tco_pkg::OFS_W-1:0] cnt_ff;
   logic [tco_pkg::OFS_W-1:0] nxt_cnt;
   logic [tco_pkg::OFS_W-1:0] len_ff;
   logic [tco_pkg::OFS_W-1:0] nxt_len;
   logic [31:0] cmda_ff;
   logic [31:0] nxt_cmda;
   logic [31:0] cmdb_ff;
   logic [31:0] nxt_cmdb;
   logic [31:0] pre_ff;
   logic [31:0] nxt_pre;
   logic [15:0] acc_ff;
   logic [15:0] nxt_acc;
   logic [16:0] sum17;
   logic [15:0] addend;
   logic [tco_pkg::OFS_W-1:0] start_ofs;
   logic [tco_pkg::OFS_W-1:0] ins_ofs;
   logic in_sum;
   logic wr_en;

   // offsets from the dropped preamble, counted on sent bytes
   assign start_ofs = pre_ff[tco_pkg::PRE_START_LSB +: tco_pkg::OFS_W];
   assign ins_ofs = pre_ff[tco_pkg::PRE_INSERT_LSB +: tco_pkg::OFS_W];

   // byte pairing and end-around carry
   always_comb begin
      in_sum = engage_ff && (cnt_ff >= start_ofs);
      // even relative position is the low byte
      if (cnt_ff[0] == start_ofs[0])
         addend = {8'h00, in_data}; // odd tail pads zero
      else
         addend = {in_data, 8'h00};
      sum17 = {1'b0, acc_ff} + {1'b0, addend};
   end

   // next-state computation
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_len = len_ff;
      nxt_cmda = cmda_ff;
      nxt_cmdb = cmdb_ff;
      nxt_pre = pre_ff;
      nxt_acc = acc_ff;
      nxt_engage = engage_ff;
      nxt_csum = csum_ff;
      in_ready = 1'b0;
      wr_en = 1'b0;
      out_valid = 1'b0;
      out_last = 1'b0;
      out_data = 8'h00;
      case (state_ff)
         tco_pkg::ST_CMDA, tco_pkg::ST_CMDB, tco_pkg::ST_PRE: begin
            in_ready = 1'b1;
            if (in_valid) begin
               nxt_cnt = cnt_ff + 12'h001;
               if (state_ff == tco_pkg::ST_CMDA)
                  nxt_cmda = {in_data, cmda_ff[31:8]};
               else if (state_ff == tco_pkg::ST_CMDB)
                  nxt_cmdb = {in_data, cmdb_ff[31:8]};
               else
                  nxt_pre = {in_data, pre_ff[31:8]}; // not sent
               if (in_last) begin
                  nxt_state = tco_pkg::ST_CMDA;
                  nxt_cnt = '0;
               end else if (cnt_ff[1:0] == tco_pkg::HDR_LAST_BYTE) begin
                  nxt_cnt = '0;
                  nxt_acc = 16'h0000;
                  if (state_ff == tco_pkg::ST_CMDA) begin
                     nxt_state = tco_pkg::ST_CMDB;
                  end else if (state_ff == tco_pkg::ST_CMDB) begin
                     // all three bits needed
                     nxt_engage = glob_en_ff
                        && cmda_ff[tco_pkg::CMDA_FIRST_SEG_BIT]
                        && nxt_cmdb[tco_pkg::CMDB_CK_REQ_BIT];
                     nxt_state = nxt_engage ? tco_pkg::ST_PRE
                                            : tco_pkg::ST_LOAD;
                  end else begin
                     nxt_state = tco_pkg::ST_LOAD;
                  end
               end
            end
         end
         tco_pkg::ST_LOAD: begin
            in_ready = 1'b1;
            if (in_valid) begin
               wr_en = 1'b1;
               nxt_cnt = cnt_ff + 12'h001;
               if (in_sum)
                  nxt_acc = sum17[15:0] + {15'h0000, sum17[16]};
               if (in_last) begin
                  nxt_len = cnt_ff;
                  nxt_cnt = '0;
                  // complement, zero left as zero
                  nxt_csum = ~nxt_acc;
                  nxt_state = tco_pkg::ST_SEND;
               end
            end
         end
         tco_pkg::ST_SEND: begin
            out_valid = 1'b1;
            out_last = (cnt_ff == len_ff);
            out_data = mem[cnt_ff[AW-1:0]];
            // overwrite in flight, low byte first
            if (engage_ff && cnt_ff == ins_ofs)
               out_data = csum_ff[7:0];
            else if (engage_ff && cnt_ff == ins_ofs + 12'h001)
               out_data = csum_ff[15:8];
            if (out_ready) begin
               nxt_cnt = cnt_ff + 12'h001;
               if (out_last) begin
                  nxt_cnt = '0;
                  nxt_state = tco_pkg::ST_CMDA;
               end
            end
         end
         default: begin
            nxt_state = tco_pkg::ST_CMDA;
            nxt_cnt = '0;
         end
      endcase
   end

   // engine registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= tco_pkg::ST_CMDA;
         cnt_ff <= '0;
         len_ff <= '0;
         cmda_ff <= 32'h0000_0000;
         cmdb_ff <= 32'h0000_0000;
         pre_ff <= 32'h0000_0000;
         acc_ff <= 16'h0000;
         engage_ff <= 1'b0;
         csum_ff <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         len_ff <= nxt_len;
         cmda_ff <= nxt_cmda;
         cmdb_ff <= nxt_cmdb;
         pre_ff <= nxt_pre;
         acc_ff <= nxt_acc;
         engage_ff <= nxt_engage;
         csum_ff <= nxt_csum;
      end
   end

   // frame store, no reset needed on data
   always_ff @(posedge clk) begin
      if (wr_en)
         mem[cnt_ff[AW-1:0]] <= in_data;
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_cmdb_done;
      state_ff == tco_pkg::ST_CMDB && in_valid && !in_last
         && cnt_ff[1:0] == tco_pkg::HDR_LAST_BYTE;
   endsequence

   sequence s_pre_done;
      state_ff == tco_pkg::ST_PRE && in_valid && !in_last
         && cnt_ff[1:0] == tco_pkg::HDR_LAST_BYTE;
   endsequence

   property p_engage;
      @(posedge clk) disable iff (rst)
      s_cmdb_done |=> engage_ff == ($past(glob_en_ff)
         && $past(cmda_ff[tco_pkg::CMDA_FIRST_SEG_BIT])
         && cmdb_ff[tco_pkg::CMDB_CK_REQ_BIT]);
   endproperty
   a_engage: assert property (p_engage)
      else $error("engage does not match enabling bits");

   property p_drop_pre;
      @(posedge clk) disable iff (rst)
      s_pre_done |=> state_ff == tco_pkg::ST_LOAD && cnt_ff == 12'h000
         && !out_valid;
   endproperty
   a_drop_pre: assert property (p_drop_pre)
      else $error("preamble word not dropped after four bytes");

   property p_pass;
      @(posedge clk) disable iff (rst)
      state_ff == tco_pkg::ST_SEND && !engage_ff
         |-> out_data == mem[cnt_ff[AW-1:0]];
   endproperty
   a_pass: assert property (p_pass)
      else $error("unrequested frame was modified");

   property p_ins_lo;
      @(posedge clk) disable iff (rst)
      state_ff == tco_pkg::ST_SEND && engage_ff && cnt_ff == ins_ofs
         && out_ready |-> out_data == csum_ff[7:0]
         ##1 (out_data == csum_ff[15:8] || state_ff != tco_pkg::ST_SEND);
   endproperty
   a_ins_lo: assert property (p_ins_lo)
      else $error("checksum bytes not inserted at offset");

   property p_before_start;
      @(posedge clk) disable iff (rst)
      state_ff == tco_pkg::ST_LOAD && in_valid && cnt_ff < start_ofs
         |=> acc_ff == $past(acc_ff);
   endproperty
   a_before_start: assert property (p_before_start)
      else $error("bytes before start offset were summed");

   property p_final;
      @(posedge clk) disable iff (rst)
      $rose(state_ff == tco_pkg::ST_SEND) |-> csum_ff == ~acc_ff;
   endproperty
   a_final: assert property (p_final)
      else $error("inserted value is not the complement of the sum");

   property p_low_byte;
      @(posedge clk) disable iff (rst)
      state_ff == tco_pkg::ST_LOAD && in_valid && in_sum
         && cnt_ff[0] == start_ofs[0] && acc_ff[15:8] == 8'h00
         |=> acc_ff == {8'h00, $past(acc_ff[7:0])} + {8'h00, $past(in_data)};
   endproperty
   a_low_byte: assert property (p_low_byte)
      else $error("even byte not added as low byte");

   property p_carry;
      @(posedge clk) disable iff (rst)
      state_ff == tco_pkg::ST_LOAD && in_valid && in_sum
         && acc_ff == 16'hffff && cnt_ff[0] == start_ofs[0]
         && in_data == 8'h01 |=> acc_ff == 16'h0001;
   endproperty
   a_carry: assert property (p_carry)
      else $error("carry not folded back");
endmodule

// ===== tco_engine_bench.sv
`timescale 1ns/1ps
module tco_engine_bench;
   localparam logic [31:0] PRE = 32'h0010000e;
   localparam logic [31:0] FS = 32'h1 << tco_pkg::CMDA_FIRST_SEG_BIT;
   localparam logic [31:0] CK = 32'h1 << tco_pkg::CMDB_CK_REQ_BIT;
   localparam logic [31:0] EN = 32'h1 << tco_pkg::CTRL_ENABLE_BIT;
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic in_valid, in_last, in_ready, out_valid, out_last, out_ready, er;
   logic [7:0] in_data, out_data;
   logic [7:0] fr[0:63];
   logic [15:0] last_c;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   tco_engine #(.DEPTH(64)) i_tco_engine (.clk(clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data),
      .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
      .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
   tco_mac_model i_tco_mac_model (.clk(clk), .rst(rst),
      .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
      .out_ready(out_ready));
   // ------------------------------------------------------------
   // clock, timeout, shared tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic put_byte(input logic [7:0] d, input logic l);
      in_valid <= 1'b1;
      in_data <= d;
      in_last <= l;
      @(posedge clk);
      while (in_ready !== 1'b1) @(posedge clk);
   endtask
   // ones-complement sum, earlier byte low, odd byte zero padded
   function automatic logic [15:0] csum(input int s, input int n);
      logic [31:0] acc;
      acc = 0;
      for (int i = s; i < n; i += 2)
         acc += {(i + 1 < n) ? fr[i + 1] : 8'h00, fr[i]};
      acc = acc[15:0] + acc[31:16];
      acc = acc[15:0] + acc[31:16];
      return ~acc[15:0];
   endfunction
   // header, preamble only when engaged, offsets past header and tail
   task automatic run_pkt(input logic [31:0] a, input logic [31:0] b,
                          input int len, input logic eng);
      int n0;
      logic [7:0] e;
      n0 = i_tco_mac_model.n_frames;
      i_tco_mac_model.rx_q.delete();
      for (int k = 0; k < 4; k++) put_byte(a[8*k+:8], 1'b0);
      for (int k = 0; k < 4; k++) put_byte(b[8*k+:8], 1'b0);
      if (eng)
         for (int k = 0; k < 4; k++) put_byte(PRE[8*k+:8], 1'b0);
      for (int i = 0; i < len; i++) put_byte(fr[i], i == len - 1);
      in_valid <= 1'b0;
      while (i_tco_mac_model.n_frames == n0) @(posedge clk);
      last_c = csum(14, len);
      chk(i_tco_mac_model.rx_q.size(), len);
      for (int i = 0; i < len; i++) begin
         e = fr[i];
         if (eng && i == 16) e = last_c[7:0];
         if (eng && i == 17) e = last_c[15:8];
         chk(i_tco_mac_model.rx_q[i], e);
      end
      $display("packet test done");
   endtask
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      {rst, psel, penable, pwrite, in_valid, in_last} = 6'h21;
      {paddr, pwdata, in_data} = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, tco_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, tco_pkg::ADDR_CTRL, EN);
      apb(1'b0, tco_pkg::ADDR_CTRL, 32'h0);
      chk(rd, EN);
      $display("register test done");
      for (int i = 0; i < 64; i++) fr[i] = 8'(i * 37 + 5);
      run_pkt(FS, CK, 31, 1'b1);
      apb(1'b0, tco_pkg::ADDR_STATUS, 32'h0);
      chk(rd[16:0], {1'b1, last_c});
      run_pkt(FS, 32'h0, 31, 1'b0);
      run_pkt(32'h0, CK, 31, 1'b0);
      for (int i = 14; i < 64; i++) fr[i] = 8'h00;
      {fr[18], fr[19]} = 16'hffff;
      run_pkt(FS, CK, 24, 1'b1);
      chk(last_c, 16'h0000);
      fr[20] = 8'h01;
      run_pkt(FS, CK, 24, 1'b1);
      chk(last_c, 16'hfffe);
      apb(1'b1, tco_pkg::ADDR_CTRL, 32'h0);
      run_pkt(FS, CK, 24, 1'b0);
      end_of_test();
   end
endmodule

// ===== tco_mac_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// mac side sink, stalls one cycle in three
// ------------------------------------------------------------
module tco_mac_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   input wire logic out_last,
   output logic out_ready
);
   logic [1:0] cnt_ff;
   logic [7:0] rx_q[$];
   int n_frames = 0;
   // stall pattern and byte capture
   always @(posedge clk) begin
      cnt_ff <= (rst || cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      if (!rst && out_valid && out_ready) begin
         rx_q.push_back(out_data);
         if (out_last) n_frames <= n_frames + 1;
      end
   end
   assign out_ready = (cnt_ff != 2'h2);
endmodule

// ===== tco_pkg.sv
package tco_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam int CTRL_ENABLE_BIT = 16;
   localparam int STAT_ENGAGED_BIT = 16;
   localparam int STAT_BUSY_BIT = 17;
   localparam logic CTRL_ENABLE_RST = 1'b0;

   // ------------------------------------------------------------
   // command words and preamble fields
   // ------------------------------------------------------------
   localparam int CMDA_FIRST_SEG_BIT = 13;
   localparam int CMDB_CK_REQ_BIT = 14;
   localparam int OFS_W = 12;
   localparam int PRE_START_LSB = 0;
   localparam int PRE_INSERT_LSB = 16;
   localparam logic [1:0] HDR_LAST_BYTE = 2'h3;

   // ------------------------------------------------------------
   // engine states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_CMDA = 3'b000,
      ST_CMDB = 3'b001,
      ST_PRE = 3'b010,
      ST_LOAD = 3'b011,
      ST_SEND = 3'b100
   } tco_state_t;
endpackage

// ===== tco_pkg_unused_guard.sv
`timescale 1ns/1ps
